/* core/ssr_pkg.sv */
// constants shared by the strip hit readout: geometry, timing, register map
// assumes a single 20 MHz reference clock and a synchronous active-high reset
package ssr_pkg;
  localparam int NSTRIP = 128;        // strip channels
  localparam int NSECT = 4;           // readout sections
  localparam int SECT_STRIPS = 32;    // strips per section
  localparam int TS_W = 10;           // time stamp width
  localparam int AMP_W = 4;           // pulse width amplitude width
  localparam int ADDR_W = 7;          // strip address width
  localparam int SLOTS = 8;           // pre-trigger slots per strip
  localparam int FIFO_DEPTH = 8;      // section queue entries
  localparam int WORD_W = 16;         // output word width
  localparam int ENTRY_W = TS_W + ADDR_W + AMP_W;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int TS_PERIOD_NS = 30;
  localparam int TS_CYCLES = (TS_PERIOD_NS < CLK_PERIOD_NS) ? 1 :
                             TS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TRIG_LATENCY_NS = 7000;
  localparam int LAT_TICKS = (TRIG_LATENCY_NS + TS_PERIOD_NS - 1) / TS_PERIOD_NS;
  localparam int SER_CLK_MHZ = 120;   // nominal line rate, above the 20 MHz step rate the speed divider allows
  localparam int PEAK_STEP_NS = 25;   // peaking time = (code + 1) * step
  // output word layout
  localparam int HW_ADDR_LSB = 0;
  localparam int HW_AMP_LSB = 7;
  localparam int HW_TYPE_BIT = 11;
  localparam int TW_TS_LSB = 0;
  localparam logic TYPE_HIT = 1'h1;
  localparam logic TYPE_TS = 1'h0;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LATENCY = 8'h04;
  localparam logic [7:0] REG_DAC0 = 8'h08;
  localparam logic [7:0] REG_DAC1 = 8'h0C;
  localparam logic [7:0] REG_MASK0 = 8'h10;
  localparam logic [7:0] REG_INJECT0 = 8'h20;
  localparam logic [7:0] REG_STATUS = 8'h30;
  localparam logic [7:0] REG_HITCNT = 8'h34;
  // control fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_POL_BIT = 1;
  localparam int CTRL_LANES_LSB = 2;
  localparam int CTRL_SPEED_LSB = 4;
  localparam int CTRL_PEAK_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] DAC_RESET = 32'h8080_8080;
  // status fields
  localparam int ST_TS_LSB = 0;
  localparam int ST_BUSY_BIT = 12;
  localparam int ST_VALID_LSB = 16;
  localparam int ST_OVF_LSB = 20;
endpackage

/* core/ssr_section.sv */
// one readout section: pulse width digitiser, pre-trigger slots, sparsifier, queue
// assumes hit inputs are synchronous to ref_clk_i and already masked upstream
`timescale 1ns/1ns
module ssr_section #(
  parameter logic [1:0] SECT_IDX = 2'h0
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [ssr_pkg::SECT_STRIPS-1:0] hit_i,
  input wire logic [ssr_pkg::TS_W-1:0] ts_i,
  input wire logic trig_i,
  input wire logic [ssr_pkg::TS_W-1:0] trig_ts_i,
  input wire logic [ssr_pkg::TS_W-1:0] latency_i,
  input wire logic out_ready_i,
  output logic out_valid_o,
  output logic [ssr_pkg::ENTRY_W-1:0] out_entry_o,
  output logic overflow_o
);
  typedef struct packed {
    logic [ssr_pkg::SECT_STRIPS-1:0] prev;  // hit level last cycle
    logic [ssr_pkg::SECT_STRIPS-1:0][ssr_pkg::AMP_W-1:0] cnt;  // width so far
    logic [ssr_pkg::SECT_STRIPS-1:0][ssr_pkg::TS_W-1:0] start_ts;  // leading edge stamp
    logic [ssr_pkg::SECT_STRIPS-1:0][ssr_pkg::SLOTS-1:0] v;  // slot occupied
    logic [ssr_pkg::SECT_STRIPS-1:0][ssr_pkg::SLOTS-1:0] sel;  // slot triggered
    logic [ssr_pkg::SECT_STRIPS-1:0][ssr_pkg::SLOTS-1:0][ssr_pkg::TS_W-1:0] sts;
    logic [ssr_pkg::SECT_STRIPS-1:0][ssr_pkg::SLOTS-1:0][ssr_pkg::AMP_W-1:0] samp;
    logic [ssr_pkg::FIFO_DEPTH-1:0][ssr_pkg::ENTRY_W-1:0] fifo;  // section queue
    logic [2:0] wptr;
    logic [2:0] rptr;
    logic [3:0] count;
    logic ovf;  // a hit found no free slot
  } ssr_sect_s;

  ssr_sect_s q;
  ssr_sect_s n;
  logic found;   // sparsifier picked a slot this cycle
  logic placed;  // falling edge found a free slot
  logic [ssr_pkg::ENTRY_W-1:0] entry;
  logic [ssr_pkg::TS_W-1:0] age;

  assign out_valid_o = (q.count != 4'h0);
  assign out_entry_o = q.fifo[q.rptr];
  assign overflow_o = q.ovf;

  // per strip and per slot update, then one sparsified entry into the queue
  always_comb begin
    n = q;
    found = 1'b0;
    placed = 1'b0;
    entry = '0;
    age = '0;
    for (int s = 0; s < ssr_pkg::SECT_STRIPS; s++) begin
      for (int k = 0; k < ssr_pkg::SLOTS; k++) begin
        age = ts_i - q.sts[s][k];
        // stale untriggered slots are freed once past the latency window
        if (q.v[s][k] && !q.sel[s][k] && (age > latency_i)) begin
          n.v[s][k] = 1'b0;
        end
        // trigger picks only slots whose stamp equals the supplied one
        if (trig_i && q.v[s][k] && (q.sts[s][k] == trig_ts_i)) begin
          n.sel[s][k] = 1'b1;
        end
      end
    end
    // queue drain toward the concentrator
    if (out_ready_i && (q.count != 4'h0)) begin
      n.rptr = q.rptr + 3'h1;
      n.count = n.count - 4'h1;
    end
    // sparsifier: first triggered slot of the section, one per cycle
    // full is judged before the drain, costing one cycle of slack but no loss
    if (q.count != 4'(ssr_pkg::FIFO_DEPTH)) begin
      for (int s = 0; s < ssr_pkg::SECT_STRIPS; s++) begin
        for (int k = 0; k < ssr_pkg::SLOTS; k++) begin
          if (!found && q.v[s][k] && q.sel[s][k]) begin
            found = 1'b1;
            entry = {q.sts[s][k], SECT_IDX, 5'(s), q.samp[s][k]};
            n.v[s][k] = 1'b0;
            n.sel[s][k] = 1'b0;
          end
        end
      end
    end
    if (found) begin
      n.fifo[q.wptr] = entry;
      n.wptr = q.wptr + 3'h1;
      n.count = n.count + 4'h1;
    end
    // pulse width digitiser and slot fill on the trailing edge
    for (int s = 0; s < ssr_pkg::SECT_STRIPS; s++) begin
      n.prev[s] = hit_i[s];
      if (hit_i[s] && !q.prev[s]) begin
        n.cnt[s] = 4'h1;
        n.start_ts[s] = ts_i;
      end else if (hit_i[s] && (q.cnt[s] != 4'hF)) begin
        n.cnt[s] = q.cnt[s] + 4'h1;
      end else if (!hit_i[s] && q.prev[s]) begin
        placed = 1'b0;
        for (int k = 0; k < ssr_pkg::SLOTS; k++) begin
          if (!placed && !n.v[s][k]) begin
            placed = 1'b1;
            n.v[s][k] = 1'b1;
            n.sel[s][k] = 1'b0;
            n.sts[s][k] = q.start_ts[s];
            n.samp[s][k] = q.cnt[s];
          end
        end
        if (!placed) begin
          n.ovf = 1'b1;
        end
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule

/* core/ssr_top.sv */
// strip hit readout top: config registers, time stamp, four sections,
// time-ordering concentrator and multi-lane serialiser
// assumes an Avalon-MM master and hit/trigger inputs synchronous to ref_clk_i
// Overview of operation
// - 128 independent strip hit inputs feed readout
// - amplitude from discriminator width, 4 bit count
// - hits held with time stamp until trigger
// - each strip owns several pre-trigger slots
// - slot depth covers hit rate times latency
// - trigger forwards only hits with matching stamp
// - four sections, one encoded hit per cycle
// - queue follows each section sparsifier
// - concentrator merges queues keeping time order
// - serial bus driven from final output stage
// - one, two or four output lanes selectable
// - serial data leaves on differential pairs
// - one fixed 16 bit word per hit
// - commands and settings arrive over the bus
// - registers hold bias converter settings
// - registers set speed and injection pattern
// - configurable input polarity for either sensor side
// - peaking time selectable 25 to 200 ns
// - hit and time stamp word layouts fixed
// - time stamp advances on every 50 ns clock
// - any strip can be disabled individually
// - every setting is readable back
`timescale 1ns/1ns
module ssr_top (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [ssr_pkg::NSTRIP-1:0] hit_i,
  input wire logic trig_i,
  input wire logic [ssr_pkg::TS_W-1:0] trig_ts_i,
  output logic [3:0] ser_p_o,
  output logic [3:0] ser_n_o,
  output logic ser_frame_o,
  output logic [63:0] dac_bias_o,
  output logic [ssr_pkg::NSTRIP-1:0] inject_o,
  output logic polarity_o,
  output logic [2:0] peak_sel_o,
  output logic [ssr_pkg::TS_W-1:0] ts_o
);
  typedef struct packed {
    logic [31:0] ctrl;       // run, polarity, lanes, speed, peaking
    logic [31:0] latency;    // stale window in time stamp ticks
    logic [1:0][31:0] dac;   // bias converter codes
    logic [3:0][31:0] mask;  // strip disable bits
    logic [3:0][31:0] inject;  // charge injection pattern
    logic [31:0] hitcnt;     // hit words sent
    logic ack;               // bus answer phase
    logic [31:0] rdata;
    logic [3:0] ts_div;
    logic [ssr_pkg::TS_W-1:0] ts;
    logic [7:0] bit_div;
    logic [15:0] shift;      // word being serialised
    logic [4:0] steps;       // shift steps left in the word
    logic busy;
    logic have_last;         // a header opened the current group
    logic [ssr_pkg::TS_W-1:0] last_ts;
    logic [3:0] ser;
    logic frame;
  } ssr_top_s;

  ssr_top_s q;
  ssr_top_s n;
  logic [ssr_pkg::NSTRIP-1:0] hit_g;
  logic [ssr_pkg::NSECT-1:0] sec_valid;
  logic [ssr_pkg::NSECT-1:0] sec_ready;
  logic [ssr_pkg::NSECT-1:0] sec_ovf;
  logic [ssr_pkg::NSECT-1:0][ssr_pkg::ENTRY_W-1:0] sec_entry;
  logic req;
  logic hit_now;
  logic [1:0] best;
  logic best_ok;
  logic [ssr_pkg::TS_W-1:0] best_age;
  logic [ssr_pkg::TS_W-1:0] cand_age;
  logic [ssr_pkg::TS_W-1:0] best_ts;
  logic [2:0] nlanes;
  logic [4:0] nsteps;
  logic [31:0] rd;
  logic [ssr_pkg::NSECT-1:0] pop;

  // disabled strips and a stopped chip contribute no hits
  assign hit_g = hit_i & ~q.mask & {ssr_pkg::NSTRIP{q.ctrl[ssr_pkg::CTRL_RUN_BIT]}};

  // four identical sections, each on a 32 strip slice
  for (genvar g = 0; g < ssr_pkg::NSECT; g++) begin : g_sect
    ssr_section #(
      .SECT_IDX(2'(g))
    ) u_sect (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .hit_i(hit_g[g*ssr_pkg::SECT_STRIPS +: ssr_pkg::SECT_STRIPS]),
      .ts_i(q.ts),
      .trig_i(trig_i),
      .trig_ts_i(trig_ts_i),
      .latency_i(q.latency[ssr_pkg::TS_W-1:0]),
      .out_ready_i(sec_ready[g]),
      .out_valid_o(sec_valid[g]),
      .out_entry_o(sec_entry[g]),
      .overflow_o(sec_ovf[g])
    );
  end

  // bus handshake: one wait cycle, then the answer
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~q.ack;
  assign avs_readdata_o = q.rdata;
  assign sec_ready = pop;

  // configuration outputs come straight from the registers
  assign dac_bias_o = q.dac;
  assign inject_o = q.inject;
  assign polarity_o = q.ctrl[ssr_pkg::CTRL_POL_BIT];
  assign peak_sel_o = q.ctrl[ssr_pkg::CTRL_PEAK_LSB +: 3];
  assign ts_o = q.ts;
  assign ser_p_o = q.ser;
  assign ser_n_o = ~q.ser;
  assign ser_frame_o = q.frame;

  // read mux over every register, settings included
  always_comb begin
    rd = 32'h0000_0000;
    unique case (avs_address_i)
      ssr_pkg::REG_CTRL: rd = q.ctrl;
      ssr_pkg::REG_LATENCY: rd = q.latency;
      ssr_pkg::REG_DAC0: rd = q.dac[0];
      ssr_pkg::REG_DAC1: rd = q.dac[1];
      ssr_pkg::REG_MASK0: rd = q.mask[0];
      ssr_pkg::REG_MASK0 + 8'h04: rd = q.mask[1];
      ssr_pkg::REG_MASK0 + 8'h08: rd = q.mask[2];
      ssr_pkg::REG_MASK0 + 8'h0C: rd = q.mask[3];
      ssr_pkg::REG_INJECT0: rd = q.inject[0];
      ssr_pkg::REG_INJECT0 + 8'h04: rd = q.inject[1];
      ssr_pkg::REG_INJECT0 + 8'h08: rd = q.inject[2];
      ssr_pkg::REG_INJECT0 + 8'h0C: rd = q.inject[3];
      ssr_pkg::REG_STATUS: begin
        rd[ssr_pkg::ST_TS_LSB +: ssr_pkg::TS_W] = q.ts;
        rd[ssr_pkg::ST_BUSY_BIT] = q.busy;
        rd[ssr_pkg::ST_VALID_LSB +: 4] = sec_valid;
        rd[ssr_pkg::ST_OVF_LSB +: 4] = sec_ovf;
      end
      ssr_pkg::REG_HITCNT: rd = q.hitcnt;
      default: rd = 32'h0000_0000;  // unmapped reads return zero
    endcase
  end

  // lane count decode: codes 2 and 3 both mean four lanes
  always_comb begin
    unique case (q.ctrl[ssr_pkg::CTRL_LANES_LSB +: 2])
      2'h0: nlanes = 3'h1;
      2'h1: nlanes = 3'h2;
      default: nlanes = 3'h4;
    endcase
    nsteps = 5'(ssr_pkg::WORD_W) >> (nlanes >> 1);
  end

  // concentrator pick: the oldest stamp at any queue head keeps time order
  always_comb begin
    best = 2'h0;
    best_ok = 1'b0;
    best_age = '0;
    cand_age = '0;
    for (int s = 0; s < ssr_pkg::NSECT; s++) begin
      cand_age = q.ts - sec_entry[s][ssr_pkg::ENTRY_W-1 -: ssr_pkg::TS_W];
      if (sec_valid[s] && (!best_ok || (cand_age > best_age))) begin
        best = 2'(s);
        best_ok = 1'b1;
        best_age = cand_age;
      end
    end
    best_ts = sec_entry[best][ssr_pkg::ENTRY_W-1 -: ssr_pkg::TS_W];
    hit_now = best_ok && !q.busy && q.have_last && (best_ts == q.last_ts);
    pop = '0;
    if (hit_now) begin
      pop[best] = 1'b1;
    end
  end

  // next state: bus, time stamp, output stage
  always_comb begin
    n = q;
    // register access, taken in the first cycle of a request
    n.ack = 1'b0;
    if (req && !q.ack) begin
      n.ack = 1'b1;
      n.rdata = avs_read_i ? rd : q.rdata;
      if (avs_write_i) begin
        for (int b = 0; b < 4; b++) begin
          if (avs_byteenable_i[b]) begin
            unique case (avs_address_i)
              ssr_pkg::REG_CTRL: n.ctrl[8*b +: 8] = avs_writedata_i[8*b +: 8];
              ssr_pkg::REG_LATENCY: n.latency[8*b +: 8] = avs_writedata_i[8*b +: 8];
              ssr_pkg::REG_DAC0: n.dac[0][8*b +: 8] = avs_writedata_i[8*b +: 8];
              ssr_pkg::REG_DAC1: n.dac[1][8*b +: 8] = avs_writedata_i[8*b +: 8];
              ssr_pkg::REG_MASK0: n.mask[0][8*b +: 8] = avs_writedata_i[8*b +: 8];
              ssr_pkg::REG_MASK0 + 8'h04: n.mask[1][8*b +: 8] = avs_writedata_i[8*b +: 8];
              ssr_pkg::REG_MASK0 + 8'h08: n.mask[2][8*b +: 8] = avs_writedata_i[8*b +: 8];
              ssr_pkg::REG_MASK0 + 8'h0C: n.mask[3][8*b +: 8] = avs_writedata_i[8*b +: 8];
              ssr_pkg::REG_INJECT0: n.inject[0][8*b +: 8] = avs_writedata_i[8*b +: 8];
              ssr_pkg::REG_INJECT0 + 8'h04: n.inject[1][8*b +: 8] = avs_writedata_i[8*b +: 8];
              ssr_pkg::REG_INJECT0 + 8'h08: n.inject[2][8*b +: 8] = avs_writedata_i[8*b +: 8];
              ssr_pkg::REG_INJECT0 + 8'h0C: n.inject[3][8*b +: 8] = avs_writedata_i[8*b +: 8];
              default: n.ctrl = n.ctrl;  // read-only or unmapped: ignored
            endcase
          end
        end
      end
    end
    // time stamp counter, one tick per TS_CYCLES clocks, every clock here
    if (q.ts_div == 4'(ssr_pkg::TS_CYCLES - 1)) begin
      n.ts_div = 4'h0;
      n.ts = q.ts + 10'h001;
    end else begin
      n.ts_div = q.ts_div + 4'h1;
    end
    // word loader: header when the stamp changes, else the hit itself
    if (!q.busy) begin
      if (!best_ok) begin
        n.have_last = 1'b0;  // an idle gap closes the group
      end else if (!hit_now) begin
        n.shift = '0;
        n.shift[ssr_pkg::HW_TYPE_BIT] = ssr_pkg::TYPE_TS;
        n.shift[ssr_pkg::TW_TS_LSB +: ssr_pkg::TS_W] = best_ts;
        n.last_ts = best_ts;
        n.have_last = 1'b1;
        n.busy = 1'b1;
        n.steps = nsteps;
      end else begin
        n.shift = '0;
        n.shift[ssr_pkg::HW_TYPE_BIT] = ssr_pkg::TYPE_HIT;
        n.shift[ssr_pkg::HW_AMP_LSB +: ssr_pkg::AMP_W] = sec_entry[best][3:0];
        n.shift[ssr_pkg::HW_ADDR_LSB +: ssr_pkg::ADDR_W] = sec_entry[best][10:4];
        n.hitcnt = q.hitcnt + 32'h0000_0001;
        n.busy = 1'b1;
        n.steps = nsteps;
      end
    end
    // serialiser: one step per bit enable, msb first, word split over lanes
    // the nominal line rate is far above this clock, so speed is a divider
    if (q.bit_div == q.ctrl[ssr_pkg::CTRL_SPEED_LSB +: 4]) begin
      n.bit_div = 8'h00;
      n.frame = 1'b0;
      n.ser = 4'h0;
      if (q.busy) begin
        for (int k = 0; k < 4; k++) begin
          n.ser[k] = (3'(k) < nlanes) ? q.shift[15-k] : 1'b0;
        end
        n.frame = (q.steps == nsteps);
        n.shift = q.shift << nlanes;
        n.steps = q.steps - 5'h01;
        if (q.steps == 5'h01) begin
          n.busy = 1'b0;
        end
      end
    end else begin
      n.bit_div = q.bit_div + 8'h01;
    end
  end

  // state register with documented power-up defaults
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      q <= '0;
      q.ctrl <= ssr_pkg::CTRL_RESET;
      q.latency <= 32'(ssr_pkg::LAT_TICKS);
      q.dac <= {ssr_pkg::DAC_RESET, ssr_pkg::DAC_RESET};
    end else begin
      q <= n;
    end
  end
endmodule

/* testbench/ssr_backend_model.sv */
// back-end receiver model: rebuilds 16 bit words from serial lane 0
// assumes one lane and one bit step per clock (speed code 0)
`timescale 1ns/1ns
module ssr_backend_model (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [3:0] ser_p_i,
  input wire logic [3:0] ser_n_i,
  input wire logic ser_frame_i,
  output logic [15:0] word_o [8],
  output int n_words_o,
  output int n_bad_o
);
  logic [15:0] shift_q; // bits gathered so far, msb first
  int bits_q; // bit steps taken in the current word
  // frame marks the first step; a word is whole after sixteen steps
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      bits_q <= 0;
      n_words_o <= 0;
      n_bad_o <= 0;
    end else begin
      if (ser_n_i !== ~ser_p_i) begin
        n_bad_o <= n_bad_o + 1;
      end
      if (ser_frame_i === 1'b1) begin
        shift_q <= {15'h0000, ser_p_i[0]};
        bits_q <= 1;
      end else if (bits_q == 15) begin
        word_o[n_words_o % 8] <= {shift_q[14:0], ser_p_i[0]};
        n_words_o <= n_words_o + 1;
        bits_q <= 0;
      end else if (bits_q > 0) begin
        shift_q <= {shift_q[14:0], ser_p_i[0]};
        bits_q <= bits_q + 1;
      end
    end
  end
endmodule

/* testbench/ssr_top_assertions.sv */
// checker for the strip hit readout top: bus handshake, lanes, stamp, settings
// assumes it is bound to ssr_top and sees only the ports of that module
`timescale 1ns/1ns
module ssr_top_assertions (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [3:0] ser_p_o,
  input wire logic [3:0] ser_n_o,
  input wire logic ser_frame_o,
  input wire logic [63:0] dac_bias_o,
  input wire logic [127:0] inject_o,
  input wire logic polarity_o,
  input wire logic [2:0] peak_sel_o,
  input wire logic [9:0] ts_o
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  wire logic req; // any bus request present
  assign req = avs_read_i | avs_write_i;
  idle_no_wait_a: assert property (!req |-> !avs_waitrequest_o)
    else $error("waitrequest high without a request");
  first_wait_a: assert property ($rose(req) |-> avs_waitrequest_o)
    else $error("no wait cycle at start of request");
  one_wait_a: assert property (req && avs_waitrequest_o ##1 req |-> !avs_waitrequest_o)
    else $error("request not answered after one wait cycle");
  read_hold_a: assert property (!$past(avs_read_i) |-> $stable(avs_readdata_o))
    else $error("read data moved without a read");
  lane_pair_a: assert property (ser_n_o == ~ser_p_o)
    else $error("serial pair sides not complementary");
  ts_step_a: assert property (!$past(reset_i) |-> ts_o == $past(ts_o) + 10'h001)
    else $error("time stamp did not advance by one");
  shaper_hold_a: assert property (!$past(avs_write_i) |->
    $stable(polarity_o) && $stable(peak_sel_o))
    else $error("polarity or peaking changed without a write");
  dac_hold_a: assert property (!$past(avs_write_i) |-> $stable(dac_bias_o))
    else $error("bias settings changed without a write");
  inject_hold_a: assert property (!$past(avs_write_i) |-> $stable(inject_o))
    else $error("injection pattern changed without a write");
  // reset values are checked while reset is applied, so no disable here
  reset_out_a: assert property (disable iff (1'b0) reset_i |=>
    ser_p_o == 4'h0 && !ser_frame_o && ts_o == 10'h000)
    else $error("serial lanes or stamp not cleared by reset");
endmodule
bind ssr_top ssr_top_assertions u_ssr_top_assertions (.ref_clk_i, .reset_i, .avs_read_i,
  .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .ser_p_o, .ser_n_o, .ser_frame_o,
  .dac_bias_o, .inject_o, .polarity_o, .peak_sel_o, .ts_o);

/* testbench/strip_hit_readout_tb_top.sv */
// testbench for the strip hit readout: register access, hit path, serial output
// assumes ssr_top with the bound checker and the back-end receiver model
`timescale 1ns/1ns
module strip_hit_readout_tb_top;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [127:0] hit_i = 128'h0;
  logic trig_i = 1'b0;
  logic [9:0] trig_ts_i = 10'h000;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [3:0] ser_p_o;
  logic [3:0] ser_n_o;
  logic ser_frame_o;
  logic [63:0] dac_bias_o;
  logic [127:0] inject_o;
  logic polarity_o;
  logic [2:0] peak_sel_o;
  logic [9:0] ts_o;
  logic [15:0] word [8]; // words seen by the receiver
  int n_words;
  int n_bad;
  int n_errors = 0;
  int samples_checked = 0;
  logic [31:0] q; // last read data
  logic [9:0] t_hit; // stamp the design sees at a hit's rise
  logic [15:0] wd; // word gathered straight off the lanes
  logic [7:0] addr_t [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h3C};
  logic [31:0] rst_t [7] = '{32'h1, 32'hEA, 32'h8080_8080, 32'h8080_8080, 32'h0, 32'h0, 32'h0};
  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  ssr_top u_ssr_top (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .hit_i(hit_i), .trig_i(trig_i), .trig_ts_i(trig_ts_i),
    .ser_p_o(ser_p_o), .ser_n_o(ser_n_o), .ser_frame_o(ser_frame_o), .dac_bias_o(dac_bias_o),
    .inject_o(inject_o), .polarity_o(polarity_o), .peak_sel_o(peak_sel_o), .ts_o(ts_o));
  ssr_backend_model u_ssr_backend_model (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .ser_p_i(ser_p_o), .ser_n_i(ser_n_o), .ser_frame_i(ser_frame_o), .word_o(word),
    .n_words_o(n_words), .n_bad_o(n_bad));
  // prints the counts and the verdict, then ends the run
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one Avalon cycle: held until waitrequest is low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int k;
    k = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    // read at the edge itself, before the design's own updates land
    @(posedge ref_clk_i);
    while (avs_waitrequest_o !== 1'b0 && k < 50) begin
      @(posedge ref_clk_i);
      k++;
    end
    if (avs_waitrequest_o !== 1'b0) begin
      n_errors++;
      give_verdict();
    end
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    // one idle edge so the next call never drives the strobe twice at once
    @(posedge ref_clk_i);
  endtask
  task automatic wait_words(input int n);
    int k;
    k = 0;
    while (n_words < n && k < 400) begin
      @(posedge ref_clk_i);
      k++;
    end
    if (n_words < n) begin
      n_errors++;
      give_verdict();
    end
  endtask
  // a one-cycle trigger carrying the stamp of the chosen crossing
  task automatic trigger(input logic [9:0] ts);
    trig_ts_i <= ts;
    trig_i <= 1'b1;
    @(posedge ref_clk_i);
    trig_i <= 1'b0;
  endtask
  // gathers one word over four lanes whose steps stand two cycles each
  task automatic grab(output logic [15:0] w);
    int k;
    k = 0;
    w = 16'h0000;
    while (ser_frame_o !== 1'b1 && k < 200) begin
      @(posedge ref_clk_i);
      k++;
    end
    if (ser_frame_o !== 1'b1) begin
      n_errors++;
      give_verdict();
    end
    // lane 0 carries the highest bit of each step
    for (int i = 0; i < 4; i++) begin
      w = {w[11:0], ser_p_o[0], ser_p_o[1], ser_p_o[2], ser_p_o[3]};
      repeat (2) @(posedge ref_clk_i);
    end
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    // power-up values, an unmapped place among them
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, addr_t[i], 32'h0, 4'hF);
      chk("reset value", rst_t[i], q);
    end
    bus(1'b1, ssr_pkg::REG_DAC0, 32'h1234_5678, 4'hF);
    bus(1'b1, ssr_pkg::REG_DAC1, 32'hAAAA_AA55, 4'h1);
    chk("bias low", 32'h1234_5678, dac_bias_o[31:0]);
    chk("bias high", 32'h8080_8055, dac_bias_o[63:32]);
    bus(1'b1, ssr_pkg::REG_INJECT0 + 8'h04, 32'hF0F0_0001, 4'hF);
    chk("inject", 32'hF0F0_0001, inject_o[63:32]);
    bus(1'b1, ssr_pkg::REG_CTRL, 32'h0000_0703, 4'hF);
    chk("polarity", 32'h1, polarity_o);
    chk("peaking", 32'h7, peak_sel_o);
    bus(1'b0, ssr_pkg::REG_CTRL, 32'h0, 4'hF);
    chk("ctrl back", 32'h0000_0703, q);
    bus(1'b1, ssr_pkg::REG_HITCNT, 32'h55, 4'hF);
    bus(1'b0, ssr_pkg::REG_HITCNT, 32'h0, 4'hF);
    chk("count before hits", 32'h0, q);
    // one lane, one step a cycle, strip 5 turned off
    bus(1'b1, ssr_pkg::REG_CTRL, 32'h0000_0001, 4'hF);
    bus(1'b1, ssr_pkg::REG_MASK0, 32'h0000_0020, 4'hF);
    hit_i[3] <= 1'b1;
    hit_i[5] <= 1'b1;
    hit_i[40] <= 1'b1;
    @(negedge ref_clk_i);
    t_hit = ts_o;
    repeat (3) @(posedge ref_clk_i);
    hit_i[3] <= 1'b0;
    repeat (7) @(posedge ref_clk_i);
    hit_i[7] <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    hit_i[7] <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    hit_i[40] <= 1'b0;
    hit_i[5] <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    trigger(t_hit);
    wait_words(3);
    repeat (80) @(posedge ref_clk_i);
    chk("words sent", 32'd3, n_words);
    chk("header", {6'h00, t_hit}, word[0]);
    chk("hit pair", 32'h1, (word[1] === 16'h0983 && word[2] === 16'h0FA8) ||
                           (word[1] === 16'h0FA8 && word[2] === 16'h0983));
    bus(1'b0, ssr_pkg::REG_HITCNT, 32'h0, 4'hF);
    chk("hit count", 32'd2, q);
    // a hit left untriggered past the latency window never comes out
    bus(1'b1, ssr_pkg::REG_LATENCY, 32'd10, 4'hF);
    hit_i[9] <= 1'b1;
    @(negedge ref_clk_i);
    t_hit = ts_o;
    repeat (2) @(posedge ref_clk_i);
    hit_i[9] <= 1'b0;
    repeat (40) @(posedge ref_clk_i);
    trigger(t_hit);
    repeat (100) @(posedge ref_clk_i);
    chk("stale words", 32'd3, n_words);
    chk("pair faults", 32'd0, n_bad);
    // four lanes at half step rate; the receiver model no longer keeps up
    bus(1'b1, ssr_pkg::REG_CTRL, 32'h0000_0019, 4'hF);
    hit_i[3] <= 1'b1;
    @(negedge ref_clk_i);
    t_hit = ts_o;
    repeat (3) @(posedge ref_clk_i);
    hit_i[3] <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    trigger(t_hit);
    grab(wd);
    chk("lane header", {6'h00, t_hit}, wd);
    grab(wd);
    chk("lane hit", 32'h0000_0983, wd);
    give_verdict();
  end
endmodule
